//--- design/dcps_pkg.sv
`default_nettype none

// Shared constants and types for the CKE power-state controller.
package dcps_pkg;

  // Commands that the user side may request.
  typedef enum logic [3:0] {
    CMD_NOP, CMD_DES, CMD_MRS, CMD_REF, CMD_ACT, CMD_PRE, CMD_PREA,
    CMD_RD, CMD_WR, CMD_ZQCL, CMD_PDE, CMD_PDX, CMD_SRE, CMD_SRX
  } dcps_cmd_t;

  // Device state as the controller tracks it.
  typedef enum logic [2:0] {
    DEV_IDLE, DEV_ACTIVE, DEV_APD, DEV_PPD, DEV_SR
  } dcps_dev_t;

  // Half period of the memory clock in system clocks (4 x 20 ns = 80 ns).
  localparam int CK_HALF_DEF = 4;

  // Number of banks and width of the bank address.
  localparam int NBANK = 8;
  localparam int BA_W  = 3;

  // Timer width and the index of each interval timer.
  localparam int TW       = 10;
  localparam int NT       = 8;
  localparam int TI_MOD   = 0;
  localparam int TI_CKE   = 1;
  localparam int TI_XS    = 2;
  localparam int TI_XSDLL = 3;
  localparam int TI_WR512 = 4;
  localparam int TI_BURST = 5;
  localparam int TI_RFC   = 6;
  localparam int TI_RP    = 7;

  // Timing figures in memory clock cycles (nCK).
  localparam int T_MRD_NCK   = 4;
  localparam int T_MOD_NCK   = 12;
  localparam int T_CKE_NCK   = 3;
  localparam int T_XS_NCK    = 108;
  localparam int T_XSDLL_NCK = 512;
  localparam int T_WRSR_NCK  = 512;
  localparam int T_BURST_NCK = 4;
  localparam int T_RFC_NCK   = 104;
  localparam int T_RP_NCK    = 6;

  // The mode-register gap covers both tMRD and tMOD, so the larger one is loaded.
  localparam int T_MODE_NCK = (T_MOD_NCK > T_MRD_NCK) ? T_MOD_NCK : T_MRD_NCK;

  // CKE may change again one cycle before tCKEmin is met.
  localparam int T_CKEH_NCK = (T_CKE_NCK > 1) ? T_CKE_NCK - 1 : 1;

  // Load value of each timer, indexed by the timer numbers above.
  localparam logic [TW-1:0] TMR_LOAD [NT] = '{
    TW'(T_MODE_NCK), TW'(T_CKEH_NCK), TW'(T_XS_NCK), TW'(T_XSDLL_NCK),
    TW'(T_WRSR_NCK), TW'(T_BURST_NCK), TW'(T_RFC_NCK), TW'(T_RP_NCK)
  };

  // Command pin codes, CS# RAS# CAS# WE# from high bit to low.
  localparam logic [3:0] PIN_NOP = 4'h7;
  localparam logic [3:0] PIN_DES = 4'hF;
  localparam logic [3:0] PIN_MRS = 4'h0;
  localparam logic [3:0] PIN_REF = 4'h1;
  localparam logic [3:0] PIN_ACT = 4'h3;
  localparam logic [3:0] PIN_PRE = 4'h2;
  localparam logic [3:0] PIN_RD  = 4'h5;
  localparam logic [3:0] PIN_WR  = 4'h4;
  localparam logic [3:0] PIN_ZQ  = 4'h6;

endpackage

`default_nettype wire

//--- design/dcps_tmr_if.sv
`default_nettype none

// Link between the controller and its interval timers.
interface dcps_tmr_if;
  import dcps_pkg::*;
  logic          tick;  // Pulse at each rising memory clock edge.
  logic [NT-1:0] load;  // Restart pulses, one per timer.
  logic [NT-1:0] busy;  // High while a timer has not yet run out.
  modport ctl (output tick, output load, input busy);
  modport tmr (input tick, input load, output busy);
endinterface

`default_nettype wire

//--- design/dcps_timer.sv
`default_nettype none

// Bank of down counters that measure intervals in memory clock cycles.
module dcps_timer (
  // Clock and reset.
  input  wire logic  sys_clk,
  input  wire logic  reset_n,
  // Control from the controller.
  dcps_tmr_if.tmr    tif
);
  import dcps_pkg::*;

  // One counter per interval.
  genvar i;
  generate
    for (i = 0; i < NT; i++) begin : g_cnt
      logic [TW-1:0] cnt_reg;   // Cycles still to run.
      logic [TW-1:0] cnt_next;  // Next count.

      // A restart wins over a tick; a running counter steps down on each tick.
      assign cnt_next = tif.load[i] ? TMR_LOAD[i] :
                        (tif.tick && cnt_reg != '0) ? cnt_reg - TW'(1) : cnt_reg;

      // The counter register.
      always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
          cnt_reg <= '0;
        end else begin
          cnt_reg <= cnt_next;
        end
      end

      // Busy while any count remains.
      assign tif.busy[i] = (cnt_reg != '0);
    end
  endgenerate

endmodule

`default_nettype wire

//--- design/dcps_ctrl.sv
// Functional notes
// - No CKE low before tMRD and tMOD.
// - Hold new CKE until tCKEmin minus one.
// - Only NOP or DESELECT during tXS.
// - No read or ODT before tXSDLL.
// - Self-refresh only from idle with REFRESH.
// - Power-down entry and exit use NOP.
// - Self-refresh exit uses NOP or DESELECT.
// - No self-refresh during read or write.
// - No write within 512 cycles after exit.
// - Unlisted state and command pairs are illegal.
// - Reset pin stays high in operation.
`default_nettype none

// Memory-controller end that drives the clock, CKE and command pins of a
// DDR3L device and guards its power-state transitions.
module dcps_ctrl #(
  parameter int CK_HALF = dcps_pkg::CK_HALF_DEF  // Memory clock half period in system clocks.
) (
  // System clock and reset.
  input  wire logic                 sys_clk,
  input  wire logic                 reset_n,
  // User request port.
  input  wire logic                 req_valid,
  input  wire dcps_pkg::dcps_cmd_t  req_cmd,
  input  wire logic [dcps_pkg::BA_W-1:0] req_bank,
  // User answer port.
  output logic                      req_done,
  output logic                      req_err,
  output dcps_pkg::dcps_dev_t       dev_state,
  // Memory device pins.
  output logic                      ddr_ck,
  output logic                      ddr_cke,
  output logic                      ddr_cs_n,
  output logic                      ddr_ras_n,
  output logic                      ddr_cas_n,
  output logic                      ddr_we_n,
  output logic [dcps_pkg::BA_W-1:0] ddr_ba,
  output logic                      ddr_a10,
  output logic                      ddr_reset_n
);
  import dcps_pkg::*;

  // Width of the clock divider counter.
  localparam int CW = $clog2(2 * CK_HALF) + 1;

  // Divider and clock pin.
  logic [CW-1:0]    div_reg;       // Position within one memory clock period.
  logic [CW-1:0]    div_next;      // Next divider position.
  logic             ck_reg;        // Memory clock output.
  logic             is_fall;       // Clock goes low at this edge; pins change here.
  logic             is_rise;       // Clock goes high at this edge; device samples here.

  // Pin and state registers.
  logic             cke_reg;       // Clock enable output.
  logic [3:0]       pin_reg;       // CS# RAS# CAS# WE#.
  logic [BA_W-1:0]  ba_reg;        // Bank address.
  logic             a10_reg;       // Address bit 10.
  logic             rst_pin_reg;   // Device reset pin.
  logic             done_reg;      // Request carried out.
  logic             err_reg;       // Request refused.
  dcps_dev_t        dev_reg;       // Tracked device state.
  dcps_dev_t        dev_next;      // Next tracked device state.
  logic [NBANK-1:0] open_reg;      // One bit per open bank.
  logic [NBANK-1:0] open_next;     // Next open-bank map.

  // Request decoding.
  logic             take;          // A request is taken at this edge.
  logic             legal;         // The request may be issued now.
  logic             go;            // Taken and legal.
  logic             cke_low;       // Device is in power-down or self-refresh.
  logic             bank_open;     // Addressed bank is open.
  logic             all_idle;      // Banks closed and no operation pending.
  logic             cke_free;      // CKE may change now.
  logic             mode_free;     // Mode register gap is over.
  logic             xs_free;       // Self-refresh exit window is over.
  logic             cke_next;      // CKE level issued with the request.
  logic [3:0]       pin_cmd;       // Pin code of the request.
  logic             a10_cmd;       // A10 level of the request.

  // Timer link.
  dcps_tmr_if tif ();

  // Interval timers.
  dcps_timer u_timer (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .tif     (tif)
  );

  // The divider wraps once per memory clock period.
  assign div_next = (div_reg == CW'(2 * CK_HALF - 1)) ? '0 : div_reg + CW'(1);
  assign is_fall  = (div_next == CW'(CK_HALF));
  assign is_rise  = (div_next == '0);

  // Clock divider and clock pin.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      div_reg <= '0;
      ck_reg  <= 1'b1;
    end else begin
      div_reg <= div_next;
      ck_reg  <= (div_next < CW'(CK_HALF));
    end
  end

  // Pins change half a period before the device samples them, so each
  // command sits centred on the rising edge that registers it together
  // with its CKE level.
  assign take = is_fall && req_valid;
  assign go   = take && legal;

  // Status terms from the tracked state and the timers.
  assign cke_low   = (dev_reg == DEV_APD) || (dev_reg == DEV_PPD) || (dev_reg == DEV_SR);
  assign bank_open = open_reg[req_bank];
  assign cke_free  = !tif.busy[TI_CKE];
  assign mode_free = !tif.busy[TI_MOD];
  assign xs_free   = !tif.busy[TI_XS];

  // Idle means banks closed, no burst, and precharge, refresh, mode and exit
  // timings all met.
  assign all_idle = (open_reg == '0) && !tif.busy[TI_BURST] && !tif.busy[TI_RP] &&
                    !tif.busy[TI_RFC] && mode_free && xs_free;

  // Legality of each request; anything not listed here is refused.
  assign legal =
    (req_cmd == CMD_NOP || req_cmd == CMD_DES)      ? 1'b1 :
    (req_cmd == CMD_PDX)                            ? (dev_reg == DEV_APD || dev_reg == DEV_PPD) && cke_free :
    (req_cmd == CMD_SRX)                            ? (dev_reg == DEV_SR) && cke_free :
    (cke_low || !xs_free)                           ? 1'b0 :
    (req_cmd == CMD_MRS || req_cmd == CMD_ZQCL)     ? all_idle :
    (req_cmd == CMD_REF)                            ? all_idle :
    (req_cmd == CMD_ACT)                            ? !bank_open && !tif.busy[TI_RP] &&
                                                      !tif.busy[TI_RFC] && mode_free :
    (req_cmd == CMD_PRE || req_cmd == CMD_PREA)     ? !tif.busy[TI_BURST] && mode_free :
    (req_cmd == CMD_RD)                             ? bank_open && !tif.busy[TI_BURST] &&
                                                      !tif.busy[TI_XSDLL] :
    (req_cmd == CMD_WR)                             ? bank_open && !tif.busy[TI_BURST] &&
                                                      !tif.busy[TI_WR512] :
    (req_cmd == CMD_PDE)                            ? cke_free && mode_free :
    (req_cmd == CMD_SRE)                            ? all_idle && cke_free :
    1'b0;

  // CKE level issued with each request.
  assign cke_next = (req_cmd == CMD_PDE || req_cmd == CMD_SRE) ? 1'b0 :
                    (req_cmd == CMD_PDX || req_cmd == CMD_SRX) ? 1'b1 : cke_reg;

  // Pin code of each request; power transitions carry NOP, self-refresh
  // entry carries REFRESH.
  assign pin_cmd =
    (req_cmd == CMD_DES)                        ? PIN_DES :
    (req_cmd == CMD_MRS)                        ? PIN_MRS :
    (req_cmd == CMD_REF || req_cmd == CMD_SRE)  ? PIN_REF :
    (req_cmd == CMD_ACT)                        ? PIN_ACT :
    (req_cmd == CMD_PRE || req_cmd == CMD_PREA) ? PIN_PRE :
    (req_cmd == CMD_RD)                         ? PIN_RD :
    (req_cmd == CMD_WR)                         ? PIN_WR :
    (req_cmd == CMD_ZQCL)                       ? PIN_ZQ :
    PIN_NOP;

  // A10 selects all banks for precharge and the long form of calibration.
  assign a10_cmd = (req_cmd == CMD_PREA) || (req_cmd == CMD_ZQCL);

  // Open-bank map: ACT opens a bank, PRE closes it, PREA closes all.
  genvar b;
  generate
    for (b = 0; b < NBANK; b++) begin : g_bank
      logic hit;  // This bank is addressed.
      assign hit = (req_bank == BA_W'(b));
      assign open_next[b] = !go                                   ? open_reg[b] :
                            (req_cmd == CMD_PREA)                 ? 1'b0 :
                            (req_cmd == CMD_PRE && hit)           ? 1'b0 :
                            (req_cmd == CMD_ACT && hit)           ? 1'b1 :
                            open_reg[b];
    end
  endgenerate

  // Tracked device state; power states move with the accepted PDE, SRE, PDX or SRX
  // request that changes CKE, other accepted commands follow the open-bank map.
  always_comb begin
    dev_next = dev_reg;
    if (go) begin
      case (req_cmd)
        // Closed banks give precharge power-down, open ones active.
        CMD_PDE: begin
          dev_next = (open_reg == '0) ? DEV_PPD : DEV_APD;
        end
        // Self-refresh; termination is unavailable there.
        CMD_SRE: begin
          dev_next = DEV_SR;
        end
        // Exits return to the bank state held before entry.
        CMD_PDX, CMD_SRX: begin
          dev_next = (open_reg == '0) ? DEV_IDLE : DEV_ACTIVE;
        end
        // Other commands follow the open-bank map; a NOP while CKE is low keeps the state.
        default: begin
          dev_next = cke_low ? dev_reg : (open_next == '0) ? DEV_IDLE : DEV_ACTIVE;
        end
      endcase
    end
  end

  // Timer tick at each rising memory clock edge.
  assign tif.tick = is_rise;

  // Timer restarts on the commands that open each interval.
  assign tif.load[TI_MOD]   = go && (req_cmd == CMD_MRS);
  assign tif.load[TI_CKE]   = go && (cke_next != cke_reg);
  assign tif.load[TI_XS]    = go && (req_cmd == CMD_SRX);
  assign tif.load[TI_XSDLL] = go && (req_cmd == CMD_SRX);
  assign tif.load[TI_WR512] = go && (req_cmd == CMD_SRX);
  assign tif.load[TI_BURST] = go && (req_cmd == CMD_RD || req_cmd == CMD_WR);
  assign tif.load[TI_RFC]   = go && (req_cmd == CMD_REF);
  assign tif.load[TI_RP]    = go && (req_cmd == CMD_PRE || req_cmd == CMD_PREA);

  // Command pins: issue an accepted request, otherwise deselect. While CKE
  // stays low the device ignores these pins, so deselect is as good as any.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pin_reg <= PIN_DES;
      ba_reg  <= '0;
      a10_reg <= 1'b0;
    end else if (go) begin
      pin_reg <= pin_cmd;
      ba_reg  <= req_bank;
      a10_reg <= a10_cmd;
    end else if (is_fall) begin
      pin_reg <= PIN_DES;
    end
  end

  // CKE changes only with an accepted transition. Power-down does no
  // refresh, so the user must exit it in time to keep refresh going.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cke_reg <= 1'b1;
    end else if (go) begin
      cke_reg <= cke_next;
    end
  end

  // Device state and bank map.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      dev_reg  <= DEV_IDLE;
      open_reg <= '0;
    end else begin
      dev_reg  <= dev_next;
      open_reg <= open_next;
    end
  end

  // Answer pulses: done for issued requests, error for refused ones.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      done_reg <= 1'b0;
      err_reg  <= 1'b0;
    end else begin
      done_reg <= go;
      err_reg  <= take && !legal;
    end
  end

  // The device reset pin is released after system reset and then held high.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rst_pin_reg <= 1'b0;
    end else begin
      rst_pin_reg <= 1'b1;
    end
  end

  // Self-refresh exit is taken by the device on a rising edge of its clock; the clock
  // here runs on regardless, so nothing more is needed on this side.

  // Outputs straight from registers.
  assign ddr_ck      = ck_reg;
  assign ddr_cke     = cke_reg;
  assign ddr_cs_n    = pin_reg[3];
  assign ddr_ras_n   = pin_reg[2];
  assign ddr_cas_n   = pin_reg[1];
  assign ddr_we_n    = pin_reg[0];
  assign ddr_ba      = ba_reg;
  assign ddr_a10     = a10_reg;
  assign ddr_reset_n = rst_pin_reg;
  assign req_done    = done_reg;
  assign req_err     = err_reg;
  assign dev_state   = dev_reg;

endmodule

`default_nettype wire

//--- sim/dcps_properties.sv
`default_nettype none

// Watches the memory pins of the power-state controller for illegal sequences.
module dcps_properties #(
  parameter int CK_HALF = dcps_pkg::CK_HALF_DEF  // Memory clock half period in system clocks.
) (
  // Clock and reset.
  input wire logic                     sys_clk,
  input wire logic                     reset_n,
  // User side.
  input wire logic                     req_valid,
  input wire dcps_pkg::dcps_cmd_t      req_cmd,
  input wire logic [dcps_pkg::BA_W-1:0] req_bank,
  input wire logic                     req_done,
  input wire logic                     req_err,
  input wire dcps_pkg::dcps_dev_t      dev_state,
  // Memory pins.
  input wire logic                     ddr_ck,
  input wire logic                     ddr_cke,
  input wire logic                     ddr_cs_n,
  input wire logic                     ddr_ras_n,
  input wire logic                     ddr_cas_n,
  input wire logic                     ddr_we_n,
  input wire logic [dcps_pkg::BA_W-1:0] ddr_ba,
  input wire logic                     ddr_a10,
  input wire logic                     ddr_reset_n
);
  import dcps_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int PER = 2 * CK_HALF;  // System clocks per memory clock.
  logic [2:0]  op;         // Row, column and write strobes of the command.
  logic        nopdes;     // A no-operation or a deselect is on the pins.
  logic        is_rd;      // A read is on the pins.
  logic        is_wr;      // A write is on the pins.
  logic        is_ref;     // A refresh code is on the pins.
  logic        cke_q_reg;  // Clock enable one system clock ago.
  dcps_dev_t   dev_q_reg;  // Tracked state one system clock ago.
  logic [15:0] age_reg, age_next;  // Cycles since clock enable last moved.
  logic [15:0] xs_reg, xs_next;    // Quiet window after self-refresh exit.
  logic [15:0] dll_reg, dll_next;  // Read and write lockout after self-refresh exit.
  logic [15:0] mod_reg, mod_next;  // Mode register settle window.

  assign op     = {ddr_ras_n, ddr_cas_n, ddr_we_n};
  assign nopdes = ddr_cs_n || op == 3'h7;
  assign is_rd  = !ddr_cs_n && op == 3'h5;
  assign is_wr  = !ddr_cs_n && op == 3'h4;
  assign is_ref = !ddr_cs_n && op == 3'h1;
  // Window counters reload on their event and run down; the age counter clears and counts up. Each measures its window.
  assign age_next = (ddr_cke != cke_q_reg) ? 16'h0000 : age_reg + {15'h0000, age_reg != 16'hFFFF};
  assign xs_next  = (ddr_cke && !cke_q_reg && dev_q_reg == DEV_SR) ? 16'(T_XS_NCK * PER - 1)
                  : xs_reg - {15'h0000, xs_reg != 16'h0000};
  assign dll_next = (ddr_cke && !cke_q_reg && dev_q_reg == DEV_SR) ? 16'(T_XSDLL_NCK * PER - 1)
                  : dll_reg - {15'h0000, dll_reg != 16'h0000};
  assign mod_next = (req_done && !ddr_cs_n && op == 3'h0) ? 16'(T_MODE_NCK * PER - 1)
                  : mod_reg - {15'h0000, mod_reg != 16'h0000};

  // History registers; reset treats clock enable as long settled.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cke_q_reg <= 1'b1;
      dev_q_reg <= DEV_IDLE;
      age_reg   <= 16'hFFFF;
      xs_reg    <= 16'h0000;
      dll_reg   <= 16'h0000;
      mod_reg   <= 16'h0000;
    end else begin
      cke_q_reg <= ddr_cke;
      dev_q_reg <= dev_state;
      age_reg   <= age_next;
      xs_reg    <= xs_next;
      dll_reg   <= dll_next;
      mod_reg   <= mod_next;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  reset_hi_a: assert property ($past(reset_n) |-> ddr_reset_n)
    else $error("device reset low during operation");
  mrs_gap_a: assert property ((!ddr_cke && cke_q_reg) |-> mod_reg == 16'h0000)
    else $error("clock enable fell inside the mode register window");
  cke_hold_a: assert property ((ddr_cke != cke_q_reg) |-> age_reg >= 16'(T_CKEH_NCK * PER - 1))
    else $error("clock enable moved too soon");
  xs_quiet_a: assert property ((xs_reg != 16'h0000) |-> nopdes)
    else $error("command inside the self-refresh exit window");
  dll_lock_a: assert property ((dll_reg != 16'h0000) |-> !is_rd && !is_wr)
    else $error("read or write before the lockout ended");
  sre_idle_a: assert property ((!ddr_cke && cke_q_reg && is_ref) |-> dev_q_reg == DEV_IDLE)
    else $error("self-refresh entered from a busy state");
  edge_cmd_a: assert property ((ddr_cke != cke_q_reg) |-> nopdes || (!ddr_cke && is_ref))
    else $error("wrong command with a clock enable change");
  low_quiet_a: assert property ((!ddr_cke && !$past(ddr_cke, PER)) |-> nopdes)
    else $error("command while clock enable held low");
  err_quiet_a: assert property (req_err |-> ddr_cs_n && $stable(ddr_cke) && $stable(dev_state))
    else $error("refused request disturbed the pins");

  sr_exit_c: cover property (ddr_cke && !cke_q_reg && dev_q_reg == DEV_SR);
  pd_entry_c: cover property (!ddr_cke && cke_q_reg && nopdes);
  refuse_c: cover property (req_err);
endmodule

bind dcps_ctrl dcps_properties #(.CK_HALF(CK_HALF)) chk_u (
  .sys_clk(sys_clk), .reset_n(reset_n), .req_valid(req_valid), .req_cmd(req_cmd),
  .req_bank(req_bank), .req_done(req_done), .req_err(req_err), .dev_state(dev_state),
  .ddr_ck(ddr_ck), .ddr_cke(ddr_cke), .ddr_cs_n(ddr_cs_n), .ddr_ras_n(ddr_ras_n),
  .ddr_cas_n(ddr_cas_n), .ddr_we_n(ddr_we_n), .ddr_ba(ddr_ba), .ddr_a10(ddr_a10),
  .ddr_reset_n(ddr_reset_n)
);

`default_nettype wire

//--- sim/dcps_dram_model.sv
`default_nettype none

// Behavioural memory device that follows clock enable and the command pins.
module dcps_dram_model (
  // Memory pins from the controller.
  input wire logic                      ddr_ck,
  input wire logic                      ddr_cke,
  input wire logic                      ddr_cs_n,
  input wire logic                      ddr_ras_n,
  input wire logic                      ddr_cas_n,
  input wire logic                      ddr_we_n,
  input wire logic [dcps_pkg::BA_W-1:0] ddr_ba,
  input wire logic                      ddr_a10,
  input wire logic                      ddr_reset_n,
  // Device view for the bench.
  output dcps_pkg::dcps_dev_t           st_reg,
  output logic                          odt_ok
);
  import dcps_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic [3:0]       pins;       // Select and strobes as one code.
  logic             cke_q_reg;  // Clock enable at the previous rising edge.
  logic [NBANK-1:0] open_reg;   // Banks with an open row.
  logic [NBANK-1:0] open_next;  // Open banks after this command.

  assign pins = {ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n};
  assign open_next = (pins == PIN_ACT) ? open_reg | (NBANK'(1) << ddr_ba)
                   : (pins == PIN_PRE && ddr_a10) ? '0
                   : (pins == PIN_PRE) ? open_reg & ~(NBANK'(1) << ddr_ba) : open_reg;
  // Termination returns as soon as clock enable rises, with no clock needed.
  assign odt_ok = (st_reg != DEV_SR) || ddr_cke;

  // The state moves on each rising memory clock from old and new clock enable.
  always @(posedge ddr_ck or negedge ddr_reset_n) begin
    if (!ddr_reset_n) begin
      st_reg    <= DEV_IDLE;
      open_reg  <= '0;
      cke_q_reg <= 1'b1;
    end else begin
      cke_q_reg <= ddr_cke;
      if (!cke_q_reg && !ddr_cke) begin
        st_reg <= st_reg; // Pins are ignored and no refresh runs here.
      end else if (!cke_q_reg) begin
        st_reg <= |open_reg ? DEV_ACTIVE : DEV_IDLE;
      end else if (!ddr_cke && pins == PIN_REF && open_reg == '0) begin
        st_reg <= DEV_SR;
      end else if (!ddr_cke && (ddr_cs_n || pins == PIN_NOP)) begin
        st_reg <= |open_reg ? DEV_APD : DEV_PPD;
      end else if (ddr_cke) begin
        open_reg <= open_next;
        st_reg   <= |open_next ? DEV_ACTIVE : DEV_IDLE;
      end
    end
  end
endmodule

`default_nettype wire

//--- sim/dcps_ctrl_tb.sv
`default_nettype none

// Drives requests into the controller and compares both state trackers.
module dcps_ctrl_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import dcps_pkg::*;

  localparam int PER = 2 * CK_HALF_DEF;  // System clocks per memory clock.
  logic            sys_clk, reset_n, req_valid, req_done, req_err;
  dcps_cmd_t       req_cmd;
  logic [BA_W-1:0] req_bank, ddr_ba;
  logic            ddr_ck, ddr_cke, cs_n, ras_n, cas_n, we_n, a10, dram_rst_n, odt_ok;
  dcps_dev_t       dev_state, mod_st;
  int              fail_count, total_checks;

  dcps_ctrl dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .req_valid(req_valid), .req_cmd(req_cmd),
    .req_bank(req_bank), .req_done(req_done), .req_err(req_err), .dev_state(dev_state),
    .ddr_ck(ddr_ck), .ddr_cke(ddr_cke), .ddr_cs_n(cs_n), .ddr_ras_n(ras_n), .ddr_cas_n(cas_n),
    .ddr_we_n(we_n), .ddr_ba(ddr_ba), .ddr_a10(a10), .ddr_reset_n(dram_rst_n));
  dcps_dram_model dram_u (.ddr_ck(ddr_ck), .ddr_cke(ddr_cke), .ddr_cs_n(cs_n), .ddr_ras_n(ras_n),
    .ddr_cas_n(cas_n), .ddr_we_n(we_n), .ddr_ba(ddr_ba), .ddr_a10(a10), .ddr_reset_n(dram_rst_n),
    .st_reg(mod_st), .odt_ok(odt_ok));

  // Free-running system clock.
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // Counts a comparison and reports a miss.
  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask

  // Holds a request until answered, then judges issued against refused.
  task automatic issue(input dcps_cmd_t c, input logic [BA_W-1:0] b, input logic refuse);
    int n;
    n = 0;
    @(posedge sys_clk);
    #1;
    req_cmd   = c;
    req_bank  = b;
    req_valid = 1'b1;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (req_done !== 1'b1 && req_err !== 1'b1 && n < 3 * PER);
    req_valid = 1'b0;
    check(req_err === refuse && req_done === !refuse, "request outcome");
  endtask

  // Lets whole memory clocks pass.
  task automatic wait_nck(input int n);
    repeat (n * PER) @(posedge sys_clk);
    #1;
  endtask

  // Both the controller and the device must agree on the state.
  task automatic expect_state(input dcps_dev_t s);
    wait_nck(1);
    check(dev_state === s && mod_st === s, "device state");
  endtask

  // Plain commands from idle, then an activate blocked by refresh.
  task automatic run_idle();
    issue(CMD_NOP, 3'h0, 1'b0);
    issue(CMD_DES, 3'h0, 1'b0);
    issue(CMD_ZQCL, 3'h0, 1'b0);
    issue(CMD_REF, 3'h0, 1'b0);
    issue(CMD_ACT, 3'h2, 1'b1);
    wait_nck(T_RFC_NCK);
    issue(CMD_ACT, 3'h2, 1'b0);
    issue(CMD_RD, 3'h2, 1'b0);
    expect_state(DEV_ACTIVE);
  endtask

  // Active power-down with an early exit and a command while asleep.
  task automatic run_apd();
    issue(CMD_PDE, 3'h0, 1'b0);
    issue(CMD_PDX, 3'h0, 1'b1);
    issue(CMD_NOP, 3'h0, 1'b0);
    expect_state(DEV_APD);
    issue(CMD_RD, 3'h2, 1'b1);
    issue(CMD_PDX, 3'h0, 1'b0);
    expect_state(DEV_ACTIVE);
  endtask

  // Precharge power-down, first blocked by a mode register write.
  task automatic run_ppd();
    issue(CMD_PREA, 3'h0, 1'b0);
    wait_nck(T_RP_NCK);
    issue(CMD_MRS, 3'h0, 1'b0);
    issue(CMD_PDE, 3'h0, 1'b1);
    wait_nck(T_MODE_NCK);
    issue(CMD_PDE, 3'h0, 1'b0);
    expect_state(DEV_PPD);
    wait_nck(T_CKE_NCK);
    issue(CMD_PDX, 3'h0, 1'b0);
    expect_state(DEV_IDLE);
  endtask

  // Self-refresh refused while busy, then entered, left and the lockouts probed.
  task automatic run_sr();
    issue(CMD_ACT, 3'h5, 1'b0);
    issue(CMD_RD, 3'h5, 1'b0);
    issue(CMD_SRE, 3'h0, 1'b1);
    wait_nck(T_BURST_NCK);
    issue(CMD_PRE, 3'h5, 1'b0);
    wait_nck(T_RP_NCK);
    issue(CMD_SRE, 3'h0, 1'b0);
    expect_state(DEV_SR);
    check(odt_ok === 1'b0, "termination in self-refresh");
    wait_nck(T_CKE_NCK);
    issue(CMD_SRX, 3'h0, 1'b0);
    issue(CMD_ACT, 3'h1, 1'b1);
    wait_nck(T_XS_NCK);
    issue(CMD_ACT, 3'h1, 1'b0);
    issue(CMD_RD, 3'h1, 1'b1);
    issue(CMD_WR, 3'h1, 1'b1);
    wait_nck(T_XSDLL_NCK - T_XS_NCK);
    issue(CMD_WR, 3'h1, 1'b0);
    expect_state(DEV_ACTIVE);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Main sequence.
  initial begin
    reset_n      = 1'b0;
    req_valid    = 1'b0;
    req_cmd      = CMD_NOP;
    req_bank     = 3'h0;
    fail_count   = 0;
    total_checks = 0;
    repeat (5) @(posedge sys_clk);
    #1 reset_n = 1'b1;
    @(posedge sys_clk);
    #1;
    run_idle();
    run_apd();
    run_ppd();
    run_sr();
    complete_run();
  end

  // Cuts a hang short well past the expected run length.
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    complete_run();
  end
endmodule

`default_nettype wire
